// File: core/ctrl_terms.sv
// Six configurable sum-or-product control terms over the interconnect literals.
`timescale 1ns/10ps
module ctrl_terms (
  input wire logic [macrocell_pkg::TERM_W-1:0] literals_i,
  input wire logic [macrocell_pkg::NUM_CT-1:0][macrocell_pkg::TERM_W-1:0] mask_i,
  input wire logic [macrocell_pkg::NUM_CT-1:0] sum_mode_i,
  output logic [macrocell_pkg::NUM_CT-1:0] term_o
);

  // An empty product is one and an empty sum is zero, so an unused term
  // should be left in sum mode.
  for (genvar k = 0; k < macrocell_pkg::NUM_CT; k++) begin : g_term
    assign term_o[k] = sum_mode_i[k] ? |(literals_i & mask_i[k]) :
                                       &(literals_i | ~mask_i[k]);
  end

endmodule // ctrl_terms

// File: core/macrocell_ctrl.sv
// Register and output control slice of one logic block of macrocells.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module macrocell_ctrl #(
  parameter int unsigned POR_CYCLES = macrocell_pkg::POR_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [macrocell_pkg::ADR_W-1:0] adr_i,
  input wire logic [macrocell_pkg::SEL_W-1:0] sel_i,
  input wire logic [macrocell_pkg::DAT_W-1:0] dat_i,
  output logic [macrocell_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  input wire logic primary_clock_i,
  input wire logic secondary_clock_i,
  input wire logic global_float_pin_n_i,
  input wire logic [macrocell_pkg::TERM_W-1:0] interconnect_array_i,
  input wire logic [macrocell_pkg::NUM_MC-1:0] logic_d_i,
  input wire logic [macrocell_pkg::NUM_MC-1:0] pad_i,
  output logic [macrocell_pkg::NUM_MC-1:0] pad_o,
  output logic [macrocell_pkg::NUM_MC-1:0] pad_oe_o,
  output logic [macrocell_pkg::NUM_MC-1:0] mc_feedback_o,
  output logic [macrocell_pkg::NUM_MC-1:0] pin_feedback_o,
  output logic por_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    macrocell_pkg::phase_t phase;
    logic [macrocell_pkg::POR_CNT_W-1:0] por_cnt;
    logic [macrocell_pkg::CTRL_W-1:0] ctrl;
    logic [macrocell_pkg::NUM_CT-1:0] ct_mode;
    logic [macrocell_pkg::NUM_CT-1:0][macrocell_pkg::TERM_W-1:0] ct_mask;
    logic [macrocell_pkg::NUM_MC-1:0][macrocell_pkg::CFG_W-1:0] mc_cfg;
    logic prim_prev;
    logic sec_prev;
    logic [macrocell_pkg::NUM_MC-1:0] q;
    logic [macrocell_pkg::NUM_MC-1:0] pad_oe;
    logic [macrocell_pkg::NUM_MC-1:0] pin_fb;
    logic [macrocell_pkg::DAT_W-1:0] dat;
    logic ack;
  } state_t;

  localparam state_t STATE_RST = '{
    phase: macrocell_pkg::PH_POR,
    ctrl: macrocell_pkg::CTRL_RST,
    ct_mode: macrocell_pkg::CT_MODE_RST,
    ct_mask: {macrocell_pkg::NUM_CT{macrocell_pkg::CT_MASK_RST}},
    mc_cfg: {macrocell_pkg::NUM_MC{macrocell_pkg::MC_CFG_RST}},
    default: '0
  };

  localparam logic [macrocell_pkg::POR_CNT_W-1:0] POR_LAST =
    macrocell_pkg::POR_CNT_W'(POR_CYCLES - 1);

  state_t s_r;
  state_t s_nxt;
  logic [macrocell_pkg::NUM_CT-1:0] ct;

  ////////////////////////////////////////////////////////////////////////////
  // Control terms, evaluated from registered configuration.
  ctrl_terms u_ctrl_terms (
    .literals_i(interconnect_array_i),
    .mask_i(s_r.ct_mask),
    .sum_mode_i(s_r.ct_mode),
    .term_o(ct)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic req;
    logic sec_src;
    logic prim_rise;
    logic prim_fall;
    logic sec_rise;
    logic sec_fall;
    logic clk_en;
    logic d_next;
    logic qn;
    logic oe;
    logic floating;
    logic [macrocell_pkg::CFG_W-1:0] cfg;
    logic [macrocell_pkg::MC_IDX_W-1:0] sec_idx;
    logic [macrocell_pkg::MC_IDX_W-1:0] cfg_idx;
    logic [2:0] mask_idx;
    logic [1:0] oe_mode;
    logic [macrocell_pkg::OE_SEL_W-1:0] oe_sel;
    logic [macrocell_pkg::DAT_W-1:0] rd;
    logic is_mask;
    logic is_cfg;
    s_nxt = s_r;
    req = 1'b0;
    sec_src = 1'b0;
    prim_rise = 1'b0;
    prim_fall = 1'b0;
    sec_rise = 1'b0;
    sec_fall = 1'b0;
    clk_en = 1'b0;
    d_next = 1'b0;
    qn = 1'b0;
    oe = 1'b0;
    floating = 1'b0;
    cfg = '0;
    oe_mode = '0;
    oe_sel = '0;
    rd = '0;
    sec_idx = s_r.ctrl[macrocell_pkg::CTRL_SEC_IDX_LSB +: macrocell_pkg::MC_IDX_W];
    cfg_idx = adr_i[2 +: macrocell_pkg::MC_IDX_W];
    mask_idx = adr_i[4:2];
    is_mask = (adr_i[7:5] == macrocell_pkg::ADDR_CT_MASK_BASE[7:5]) &&
              (adr_i[1:0] == 2'h0) && (mask_idx < 3'(macrocell_pkg::NUM_CT));
    is_cfg = (adr_i[7:6] == macrocell_pkg::ADDR_MC_CFG_BASE[7:6]) &&
             (adr_i[1:0] == 2'h0);

    // Power-on sequencing: the macrocell flip-flops are held clear until the count ends.
    case (s_r.phase)
      macrocell_pkg::PH_POR: begin
        if (s_r.por_cnt >= POR_LAST) begin
          s_nxt.phase = macrocell_pkg::PH_RUN;
        end else begin
          s_nxt.por_cnt = s_r.por_cnt + 1'b1;
        end
      end
      macrocell_pkg::PH_RUN: begin
        s_nxt.por_cnt = s_r.por_cnt;
      end
      default: begin
        s_nxt.phase = macrocell_pkg::PH_POR;
      end
    endcase

    // Clock edges are found by comparing with the previous sample, so a
    // clock pin must stay below half the system clock rate.
    sec_src = s_r.ctrl[macrocell_pkg::CTRL_SEC_LOGIC_BIT] ? s_r.q[sec_idx] :
              secondary_clock_i;
    prim_rise = primary_clock_i & ~s_r.prim_prev;
    prim_fall = ~primary_clock_i & s_r.prim_prev;
    sec_rise = sec_src & ~s_r.sec_prev;
    sec_fall = ~sec_src & s_r.sec_prev;
    s_nxt.prim_prev = primary_clock_i;
    s_nxt.sec_prev = sec_src;
    floating = s_r.ctrl[macrocell_pkg::CTRL_GTS_EN_BIT] & ~global_float_pin_n_i;

    for (int m = 0; m < macrocell_pkg::NUM_MC; m++) begin
      cfg = s_r.mc_cfg[m];
      if (cfg[macrocell_pkg::CFG_SEC_CLK_BIT]) begin
        clk_en = cfg[macrocell_pkg::CFG_FALL_BIT] ? sec_fall : sec_rise;
      end else begin
        clk_en = cfg[macrocell_pkg::CFG_FALL_BIT] ? prim_fall : prim_rise;
      end
      d_next = cfg[macrocell_pkg::CFG_TOGGLE_BIT] ? (s_r.q[m] ^ logic_d_i[m]) :
               logic_d_i[m];
      qn = clk_en ? d_next : s_r.q[m];
      if (!cfg[macrocell_pkg::CFG_PR_DIS_BIT]) begin
        if (ct[macrocell_pkg::CT_PRESET]) begin
          qn = 1'b1;
        end else if (ct[macrocell_pkg::CT_RESET]) begin
          qn = 1'b0;
        end
      end
      if (s_r.phase == macrocell_pkg::PH_POR) begin
        qn = 1'b0;
      end
      s_nxt.q[m] = qn;

      oe_mode = cfg[macrocell_pkg::CFG_OE_MODE_LSB +: 2];
      oe_sel = cfg[macrocell_pkg::CFG_OE_SEL_LSB +: macrocell_pkg::OE_SEL_W];
      case (oe_mode)
        macrocell_pkg::OE_MODE_TERM: oe = ct[macrocell_pkg::CT_OE_BASE + oe_sel];
        macrocell_pkg::OE_MODE_ON: oe = 1'b1;
        default: oe = 1'b0;
      endcase
      s_nxt.pad_oe[m] = oe & ~floating;
    end

    // Pin level is taken after the buffer; it equals the driven value while
    // the buffer is on and the outside level while it floats.
    s_nxt.pin_fb = pad_i;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack for exactly one cycle.
    req = cyc_i & stb_i & ~s_r.ack;
    s_nxt.ack = req;
    if (req && we_i && sel_i[0]) begin
      case (adr_i)
        macrocell_pkg::ADDR_CTRL: s_nxt.ctrl = dat_i[macrocell_pkg::CTRL_W-1:0];
        macrocell_pkg::ADDR_CT_MODE: s_nxt.ct_mode = dat_i[macrocell_pkg::NUM_CT-1:0];
        default: begin
          if (is_mask) begin
            s_nxt.ct_mask[mask_idx] = dat_i[macrocell_pkg::TERM_W-1:0];
          end else if (is_cfg) begin
            s_nxt.mc_cfg[cfg_idx] = dat_i[macrocell_pkg::CFG_W-1:0];
          end
        end
      endcase
    end
    case (adr_i)
      macrocell_pkg::ADDR_CTRL: rd = {24'h000000, s_r.ctrl};
      macrocell_pkg::ADDR_STATUS: begin
        rd[macrocell_pkg::STATUS_POR_DONE_BIT] = (s_r.phase == macrocell_pkg::PH_RUN);
      end
      macrocell_pkg::ADDR_MC_STATE: rd = {16'h0000, s_r.q};
      macrocell_pkg::ADDR_PIN_STATE: rd = {16'h0000, s_r.pin_fb};
      macrocell_pkg::ADDR_CT_MODE: rd = {26'h0000000, s_r.ct_mode};
      macrocell_pkg::ADDR_CT_VALUE: rd = {26'h0000000, ct};
      default: begin
        if (is_mask) begin
          rd = {24'h000000, s_r.ct_mask[mask_idx]};
        end else if (is_cfg) begin
          rd = {24'h000000, s_r.mc_cfg[cfg_idx]};
        end
      end
    endcase
    s_nxt.dat = (req && !we_i) ? rd : '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dat_o = s_r.dat;
  assign ack_o = s_r.ack;
  assign pad_o = s_r.q;
  assign pad_oe_o = s_r.pad_oe;
  assign mc_feedback_o = s_r.q;
  assign pin_feedback_o = s_r.pin_fb;
  assign por_done_o = (s_r.phase == macrocell_pkg::PH_RUN);

endmodule // macrocell_ctrl

// File: core/macrocell_pkg.sv
// Constants, register map and field layout of the macrocell control slice.
package macrocell_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes of one logic block.
  localparam int NUM_MC = 16;
  localparam int NUM_CT = 6;
  localparam int NUM_OE_CT = 4;
  localparam int TERM_W = 8;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int MC_IDX_W = 4;
  localparam int OE_SEL_W = 2;
  localparam int CFG_W = 8;
  localparam int CTRL_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Control term roles.
  localparam int CT_PRESET = 0;
  localparam int CT_RESET = 1;
  localparam int CT_OE_BASE = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MC_STATE = 8'h08;
  localparam logic [7:0] ADDR_PIN_STATE = 8'h0c;
  localparam logic [7:0] ADDR_CT_MODE = 8'h10;
  localparam logic [7:0] ADDR_CT_VALUE = 8'h14;
  localparam logic [7:0] ADDR_CT_MASK_BASE = 8'h20;
  localparam logic [7:0] ADDR_MC_CFG_BASE = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int CTRL_GTS_EN_BIT = 0;
  localparam int CTRL_SEC_LOGIC_BIT = 1;
  localparam int CTRL_SEC_IDX_LSB = 4;
  localparam int STATUS_POR_DONE_BIT = 0;
  localparam int CFG_TOGGLE_BIT = 0;
  localparam int CFG_SEC_CLK_BIT = 1;
  localparam int CFG_FALL_BIT = 2;
  localparam int CFG_PR_DIS_BIT = 3;
  localparam int CFG_OE_MODE_LSB = 4;
  localparam int CFG_OE_SEL_LSB = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Output enable modes.
  localparam logic [1:0] OE_MODE_TERM = 2'h0;
  localparam logic [1:0] OE_MODE_ON = 2'h1;
  localparam logic [1:0] OE_MODE_OFF = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values. Terms reset to empty sums, which evaluate to zero.
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [CFG_W-1:0] MC_CFG_RST = 8'h20;
  localparam logic [NUM_CT-1:0] CT_MODE_RST = 6'h3f;
  localparam logic [TERM_W-1:0] CT_MASK_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Power-on timing.
  localparam int CLK_MHZ = 125;
  localparam int POR_TIME_US = 50;
  localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
  localparam int POR_CNT_W = 13;

  typedef enum logic {PH_POR, PH_RUN} phase_t;

endpackage

// File: tb/board_model.sv
// Board-side model: drives released pins and the global float pin.
`timescale 1ns/10ps
module board_model (
  input wire logic [macrocell_pkg::NUM_MC-1:0] pad_val_i,
  input wire logic [macrocell_pkg::NUM_MC-1:0] pad_oe_i,
  input wire logic [macrocell_pkg::NUM_MC-1:0] drive_i,
  input wire logic float_req_i,
  output logic [macrocell_pkg::NUM_MC-1:0] level_o,
  output logic float_pin_n_o
);
  // A released pin shows the board level drive_i, whatever the device last drove.
  assign level_o = (pad_val_i & pad_oe_i) | (drive_i & ~pad_oe_i);
  assign float_pin_n_o = !float_req_i;
endmodule // board_model

// File: tb/macrocell_ctrl_asserts.sv
// Concurrent checks on the ports of the macrocell control slice.
`timescale 1ns/10ps
module macrocell_ctrl_asserts #(
  parameter int unsigned POR_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic global_float_pin_n_i,
  input wire logic [15:0] pad_i,
  input wire logic [15:0] pad_o,
  input wire logic [15:0] pad_oe_o,
  input wire logic [15:0] mc_feedback_o,
  input wire logic [15:0] pin_feedback_o,
  input wire logic por_done_o
);
  logic gf_r;
  int unsigned cnt_r;
  // Shadow of the float enable bit, so the float check needs no internal probe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gf_r <= 1'b0;
      cnt_r <= 0;
    end else begin
      if (cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == 8'h00) gf_r <= dat_i[0];
      if (cnt_r < POR_CYCLES + 4) cnt_r <= cnt_r + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == '0) else $error("read data outside ack");
  AST_RST_CLEAR: assert property (disable iff (1'b0) rst_i |=> !ack_o && pad_o == '0 &&
    pad_oe_o == '0 && !por_done_o) else $error("outputs not cleared by reset");
  AST_POR_ZERO: assert property (!por_done_o |-> pad_o == '0)
    else $error("flip-flop set during power-on");
  AST_POR_EARLY: assert property (cnt_r < POR_CYCLES |-> !por_done_o)
    else $error("power-on ended early");
  AST_POR_LATE: assert property (cnt_r > POR_CYCLES + 2 |-> por_done_o)
    else $error("power-on ended late");
  AST_FB_MC: assert property (mc_feedback_o == pad_o)
    else $error("macrocell feedback differs from result");
  AST_FB_PIN: assert property (!$past(rst_i) |-> pin_feedback_o == $past(pad_i))
    else $error("pin feedback wrong");
  AST_FLOAT: assert property (gf_r && !global_float_pin_n_i |=> pad_oe_o == '0)
    else $error("outputs not floated");
endmodule // macrocell_ctrl_asserts
bind macrocell_ctrl macrocell_ctrl_asserts #(.POR_CYCLES(POR_CYCLES)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .global_float_pin_n_i(global_float_pin_n_i), .pad_i(pad_i), .pad_o(pad_o),
  .pad_oe_o(pad_oe_o), .mc_feedback_o(mc_feedback_o), .pin_feedback_o(pin_feedback_o),
  .por_done_o(por_done_o));

// File: tb/testbench.sv
// Self-checking bench of the macrocell control slice.
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, por_done_o, pc, sc, fl_req, fl_n;
  logic [7:0] adr_i, lits;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, ev;
  logic [15:0] d_i, pad_i, pad_o, pad_oe_o, ext, e, r, mfb, pfb;
  logic [31:0] exp_q[$];
  int failures, checks_done, seed, k;
  macrocell_ctrl #(.POR_CYCLES(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .primary_clock_i(pc), .secondary_clock_i(sc), .global_float_pin_n_i(fl_n),
    .interconnect_array_i(lits), .logic_d_i(d_i), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_o(pad_oe_o), .mc_feedback_o(mfb), .pin_feedback_o(pfb), .por_done_o(por_done_o));
  board_model brd_u (.pad_val_i(pad_o), .pad_oe_i(pad_oe_o), .drive_i(ext),
    .float_req_i(fl_req), .level_o(pad_i), .float_pin_n_o(fl_n));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    {cyc_i, stb_i} <= 2'b00;
    if (n >= 50) begin
      failures++;
      report_and_stop();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_por();
    k = 0;
    while (por_done_o !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    if (k >= 200) begin
      failures++;
      report_and_stop();
    end
  endtask
  // Read data is compared against the oldest note when ack appears.
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      ev = exp_q.pop_front();
      `CHK(dat_o, ev)
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = '0;
    {rst_i, pc, sc, fl_req, lits, d_i, ext} = {4'b1010, 8'h00, 16'h0000, 16'ha5c3};
    seed = 80607;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h20);
    rd(8'h10, 32'h3f);
    wr(8'hfc, 32'hff);
    rd(8'hfc, 32'h0);
    wait_por();
    rd(8'h08, 32'h0);
    $display("end of test: reset and power-on");
    for (k = 0; k < 16; k++) wr(8'h40 + 8'(4 * k), k[0] ? 32'h16 : 32'h10);
    r = 16'($random(seed));
    d_i <= r;
    pc <= 1'b1;
    tick(3);
    e = r & 16'h5555;
    r = 16'($random(seed));
    d_i <= r;
    sc <= 1'b0;
    tick(3);
    e = e | (r & 16'haaaa);
    rd(8'h08, {16'h0, e});
    d_i <= ~r;
    {pc, sc} <= 2'b01;
    tick(3);
    rd(8'h08, {16'h0, e});
    `CHK(pad_oe_o, 16'hffff)
    for (k = 0; k < 16; k++) wr(8'h40 + 8'(4 * k), 32'h11);
    r = 16'($random(seed));
    d_i <= r;
    pc <= 1'b1;
    tick(3);
    e = e ^ r;
    rd(8'h08, {16'h0, e});
    `CHK(mfb, e)
    $display("end of test: clocking");
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h2);
    wr(8'h44, 32'h19);
    lits <= 8'h01;
    tick(3);
    e = 16'hfffd | (e & 16'h0002);
    rd(8'h08, {16'h0, e});
    lits <= 8'h03;
    tick(3);
    rd(8'h08, {16'h0, e});
    lits <= 8'h02;
    tick(3);
    e = e & 16'h0002;
    rd(8'h08, {16'h0, e});
    wr(8'h10, 32'h3e);
    wr(8'h20, 32'h3);
    lits <= 8'h01;
    tick(3);
    rd(8'h14, 32'h0);
    lits <= 8'h03;
    tick(3);
    rd(8'h14, 32'h3);
    rd(8'h08, {16'h0, 16'hfffd | e});
    $display("end of test: preset and reset");
    for (k = 0; k < 16; k++) wr(8'h40 + 8'(4 * k), k == 0 ? 32'h10 : k == 2 ? 32'h0 : k == 3 ? 32'hc0 : 32'h20);
    wr(8'h28, 32'h4);
    wr(8'h34, 32'h8);
    r = 16'($random(seed));
    {lits, ext} <= {8'h04, r};
    tick(3);
    `CHK(pad_oe_o, 16'h0005)
    rd(8'h0c, {16'h0, (16'hfffd & 16'h0005) | (r & 16'hfffa)});
    `CHK(pfb, 16'h0005 | (r & 16'hfffa))
    lits <= 8'h08;
    tick(3);
    `CHK(pad_oe_o, 16'h0009)
    wr(8'h00, 32'h1);
    fl_req <= 1'b1;
    tick(3);
    `CHK(pad_oe_o, 16'h0000)
    fl_req <= 1'b0;
    tick(3);
    `CHK(pad_oe_o, 16'h0009)
    wr(8'h00, 32'h0);
    fl_req <= 1'b1;
    tick(3);
    `CHK(pad_oe_o, 16'h0009)
    $display("end of test: output enables");
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h20);
    wait_por();
    $display("end of test: second reset");
    report_and_stop();
  end
endmodule // testbench
